// >>> hdl/ctsa_pkg.sv
package ctsa_pkg;
	// timing
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          STEP_TIME_NS  = 5000000;
	localparam int          STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
	// register byte offsets
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_LIMIT     = 8'h04;
	localparam logic [7:0]  OFF_RATIO     = 8'h08;
	localparam logic [7:0]  OFF_SUMD      = 8'h0C;
	localparam logic [7:0]  OFF_DELAY     = 8'h10;
	localparam logic [7:0]  OFF_STAT      = 8'h14;
	localparam logic [7:0]  OFF_DIFF      = 8'h18;
	localparam logic [7:0]  OFF_ANG       = 8'h1C;
	localparam logic [7:0]  OFF_LEFT      = 8'h20;
	localparam logic [7:0]  OFF_RSEL      = 8'h24;
	localparam logic [7:0]  OFF_REC0      = 8'h28;
	localparam logic [7:0]  OFF_REC_END   = 8'h40;
	// control fields
	localparam int          CTRL_RES_LSB  = 0;
	localparam int          CTRL_FORCE_EN = 2;
	localparam int          CTRL_FORCE_BK = 3;
	localparam int          CTRL_KEEP_ON  = 4;
	localparam int          CTRL_KEEP_OFF = 5;
	// reset values, currents in 0.01 xIn, ratios in 0.01 %, delay in 5 ms steps
	localparam logic [31:0] CTRL_RST      = 32'h0000_0030;
	localparam logic [31:0] LIMIT_RST     = 32'h000A_0078;
	localparam logic [31:0] RATIO_RST     = 32'h1324_03E8;
	localparam logic [15:0] SUMD_RST      = 16'h000A;
	localparam logic [18:0] DELAY_RST     = 19'h000C8;
	// hysteresis and ratio scale
	localparam logic [7:0]  HYST_LO       = 8'h61;
	localparam logic [7:0]  HYST_HI       = 8'h67;
	localparam logic [23:0] PCT           = 24'h000064;
	localparam logic [15:0] RATIO_FULL    = 16'h2710;
	// widths and record store
	localparam int          CUR_W         = 16;
	localparam int          DLY_W         = 19;
	localparam int          REC_DEPTH     = 12;
	localparam int          REC_WORDS     = 6;
	localparam int          REC_W         = 32 * REC_WORDS;
	localparam logic [3:0]  REC_LAST      = 4'hB;
	localparam logic [3:0]  REC_FULL      = 4'hC;

	typedef enum logic [1:0] {EV_ALARM_ON, EV_ALARM_OFF, EV_BLOCK_ON, EV_BLOCK_OFF} ctsa_event_t;
	typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} ctsa_status_t;
endpackage : ctsa_pkg

// >>> hdl/ctsa_rec_mem.sv
`timescale 1ns/100ps
module ctsa_rec_mem #(
	parameter int W  = 192,
	parameter int D  = 12,
	parameter int AW = 4
) (
	// clock
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read side
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);
	logic [W-1:0] mem [D];

	// array has no reset: unread slots are masked by the record count above
	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[raddr];
		end
	end
endmodule : ctsa_rec_mem

// >>> hdl/ctsa_dt_timer.sv
`timescale 1ns/100ps
module ctsa_dt_timer #(
	parameter int STEP_CYCLES = ctsa_pkg::STEP_CYCLES
) (
	// clock
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// control
	input  wire logic                       run,
	input  wire logic [ctsa_pkg::DLY_W-1:0] delay,
	// result
	output logic                            alarm,
	output logic      [ctsa_pkg::DLY_W-1:0] remain
);
	logic [31:0]                pre_q;
	logic [ctsa_pkg::DLY_W-1:0] cnt_q;

	// fixed delay only, release is immediate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= '0;
			cnt_q <= '0;
		end else if (!run) begin
			pre_q <= '0;
			cnt_q <= '0;
		end else if (cnt_q < delay) begin
			if (pre_q == 32'(STEP_CYCLES - 1)) begin
				pre_q <= '0;
				cnt_q <= cnt_q + 1'b1;
			end else begin
				pre_q <= pre_q + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm <= 1'b0;
		end else begin
			alarm <= run && (cnt_q >= delay);
		end
	end

	assign remain = (cnt_q < delay) ? delay - cnt_q : '0;

	alarm_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(alarm) |-> $past(run) && ($past(cnt_q) >= $past(delay)))
		else $error("alarm rose before the delay elapsed");
	release_now_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!run |=> !alarm && (cnt_q == '0))
		else $error("alarm or count survived a release");
endmodule : ctsa_dt_timer

// >>> hdl/ctsa_supervision.sv
// Contract
// - blocking is sampled once at every program cycle start, before pick-up is used
// - pick-up with blocking inactive asserts start and begins delay timing
// - pick-up with blocking active asserts blocked and nothing more
// - blocking after start clears start and releases like a pick-up drop
// - blocking raises a notification and a stamped event with currents and fault
// - in forcing test mode a software switch drives the blocking input
// - timing is definite delay only, no inverse curves
// - alarm only when all conditions persist for the whole configured time
// - any phase above the upper limit keeps the function inactive
// - all phases below the lower limit keep the function inactive
// - with a residual input selected, summed phases are compared to residual
// - no activation while the residual difference stays below its threshold
// - alarm and blocked changes make events, rising, falling or both kept
// - four event kinds, each stored with time stamp and process data
// - the twelve newest operation records are kept, older ones dropped
// - record holds time, event, currents, time left, fault code, setting group
// - status reads 0 normal, 1 start, 2 trip, 3 blocked
// - magnitude and angle difference of summed phases and residual are published
// - natural unbalance angle after compensation is published
// - current thresholds release at 97 and 103 percent of the setting
// - start only while blocking is inactive; pick-up alone is not start
// - alarm delay counts in steps of 5 ms
`timescale 1ns/100ps
module ctsa_supervision #(
	parameter int STEP_CYCLES = ctsa_pkg::STEP_CYCLES
) (
	// ahb-lite
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic      [31:0]                hrdata,
	// measurement front end, same clock
	input  wire logic                       cycle_start,
	input  wire logic [ctsa_pkg::CUR_W-1:0] phase_l1,
	input  wire logic [ctsa_pkg::CUR_W-1:0] phase_l2,
	input  wire logic [ctsa_pkg::CUR_W-1:0] phase_l3,
	input  wire logic [ctsa_pkg::CUR_W-1:0] residual_input_one,
	input  wire logic [ctsa_pkg::CUR_W-1:0] residual_input_two,
	input  wire logic [ctsa_pkg::CUR_W-1:0] pos_seq_current,
	input  wire logic [ctsa_pkg::CUR_W-1:0] neg_seq_current,
	input  wire logic [ctsa_pkg::CUR_W-1:0] calc_residual,
	input  wire logic [15:0]                residual_angle_diff,
	input  wire logic [15:0]                natural_unbalance_ang,
	input  wire logic [31:0]                time_stamp,
	input  wire logic [2:0]                 setting_group,
	// blocking matrix pin
	input  wire logic                       block_in,
	// outputs
	output logic                            start_out,
	output logic                            blocked_out,
	output logic                            alarm_out,
	output logic                            block_note,
	output ctsa_pkg::ctsa_status_t          status_code
);
	logic [31:0]                ctrl_q, limit_q, ratio_q;
	logic [15:0]                sumd_q;
	logic [ctsa_pkg::DLY_W-1:0] delay_q;
	logic [3:0]                 rsel_q;
	logic                       wr_q, rd_q, aok_q, ready_q;
	logic [7:0]                 addr_q;
	logic [31:0]                rdata_q, rmux;
	logic                       blk_s1_q, blk_s2_q, blk_q, blk_src;
	logic                       over_q, low_q, dif_q, pick_q, start_q, blocked_q;
	logic                       over_d, low_d, dif_d, pick_d, ratio_ok, seq_ok, res_used;
	logic [15:0]                up_lim, lo_lim, mx, mn, res_meas, diff_mag;
	logic [15:0]                diff_q, ang_q, nat_q;
	logic [3:0]                 fault_d;
	logic                       alarm_t, alarm_q, note_q;
	logic [ctsa_pkg::DLY_W-1:0] remain;
	logic                       keep_on, keep_off, blk_ev, alm_ev, pend_q, pend_on_q, rec_we;
	ctsa_pkg::ctsa_event_t      rec_kind;
	logic [ctsa_pkg::REC_W-1:0] rec_wdata, rec_rdata;
	logic [3:0]                 wp_q, cnt_q, rec_raddr;
	logic [4:0]                 ra_t;
	logic                       ap;
	ctsa_pkg::ctsa_status_t     status_q;

	function automatic logic [15:0] pct(input logic [15:0] x, input logic [7:0] p);
		logic [23:0] t;
		t = x * p;
		return 16'(t / ctsa_pkg::PCT);
	endfunction : pct
	// bus slave: writes take no wait, reads one wait state so hrdata is a flop
	assign ap = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			aok_q  <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q <= ap && hwrite && (hsize == 3'h2);
			rd_q <= ap && !hwrite;
			if (ap) begin
				addr_q <= haddr[7:0];
				aok_q  <= (haddr[31:8] == 24'h000000);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			hresp   <= 1'b0;
		end else begin
			ready_q <= !(ap && !hwrite);
			hresp   <= 1'b0;
			if (rd_q) begin
				rdata_q <= rmux;
			end
		end
	end

	assign hreadyout = ready_q;
	assign hrdata    = rdata_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= ctsa_pkg::CTRL_RST;
			limit_q <= ctsa_pkg::LIMIT_RST;
			ratio_q <= ctsa_pkg::RATIO_RST;
			sumd_q  <= ctsa_pkg::SUMD_RST;
			delay_q <= ctsa_pkg::DELAY_RST;
			rsel_q  <= 4'h0;
		end else if (wr_q && aok_q) begin
			if (addr_q == ctsa_pkg::OFF_CTRL) begin
				ctrl_q <= {26'h0000000, hwdata[5:0]};
			end else if (addr_q == ctsa_pkg::OFF_LIMIT) begin
				limit_q <= hwdata;
			end else if (addr_q == ctsa_pkg::OFF_RATIO) begin
				ratio_q <= hwdata;
			end else if (addr_q == ctsa_pkg::OFF_SUMD) begin
				sumd_q <= hwdata[15:0];
			end else if (addr_q == ctsa_pkg::OFF_DELAY) begin
				delay_q <= hwdata[ctsa_pkg::DLY_W-1:0];
			end else if (addr_q == ctsa_pkg::OFF_RSEL && hwdata[3:0] <= ctsa_pkg::REC_LAST) begin
				rsel_q <= hwdata[3:0];
			end
		end
	end

	always_comb begin
		rmux = 32'h0000_0000;
		if (!aok_q) begin
			rmux = 32'h0000_0000;
		end else if (addr_q == ctsa_pkg::OFF_CTRL) begin
			rmux = ctrl_q;
		end else if (addr_q == ctsa_pkg::OFF_LIMIT) begin
			rmux = limit_q;
		end else if (addr_q == ctsa_pkg::OFF_RATIO) begin
			rmux = ratio_q;
		end else if (addr_q == ctsa_pkg::OFF_SUMD) begin
			rmux = {16'h0000, sumd_q};
		end else if (addr_q == ctsa_pkg::OFF_DELAY) begin
			rmux = {13'h0000, delay_q};
		end else if (addr_q == ctsa_pkg::OFF_STAT) begin
			rmux = {19'h00000, cnt_q, 3'h0, pick_q, blocked_q, alarm_q, start_q, status_q};
		end else if (addr_q == ctsa_pkg::OFF_DIFF) begin
			rmux = {ang_q, diff_q};
		end else if (addr_q == ctsa_pkg::OFF_ANG) begin
			rmux = {16'h0000, nat_q};
		end else if (addr_q == ctsa_pkg::OFF_LEFT) begin
			rmux = {13'h0000, remain};
		end else if (addr_q == ctsa_pkg::OFF_RSEL) begin
			rmux = {28'h0000000, rsel_q};
		end else if (addr_q >= ctsa_pkg::OFF_REC0 && addr_q < ctsa_pkg::OFF_REC_END) begin
			if (rsel_q < cnt_q) begin
				rmux = rec_rdata[32 * 32'((addr_q - ctsa_pkg::OFF_REC0) >> 2) +: 32];
			end
		end
	end
	// blocking pin crosses into hclk through two flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blk_s1_q <= 1'b0;
			blk_s2_q <= 1'b0;
		end else begin
			blk_s1_q <= block_in;
			blk_s2_q <= blk_s1_q;
		end
	end

	assign blk_src = ctrl_q[ctsa_pkg::CTRL_FORCE_EN] ? ctrl_q[ctsa_pkg::CTRL_FORCE_BK]
	                                                 : blk_s2_q;
	// pick-up evaluation
	assign up_lim   = limit_q[15:0];
	assign lo_lim   = limit_q[31:16];
	assign mx       = (phase_l1 > phase_l2) ? ((phase_l1 > phase_l3) ? phase_l1 : phase_l3)
	                                        : ((phase_l2 > phase_l3) ? phase_l2 : phase_l3);
	assign mn       = (phase_l1 < phase_l2) ? ((phase_l1 < phase_l3) ? phase_l1 : phase_l3)
	                                        : ((phase_l2 < phase_l3) ? phase_l2 : phase_l3);
	assign res_used = (ctrl_q[1:0] != 2'h0);
	assign res_meas = (ctrl_q[1:0] == 2'h1) ? residual_input_one : residual_input_two;
	assign diff_mag = (calc_residual >= res_meas) ? calc_residual - res_meas
	                                              : res_meas - calc_residual;
	assign over_d   = over_q ? (mx >= pct(up_lim, ctsa_pkg::HYST_LO)) : (mx > up_lim);
	assign low_d    = low_q ? (mx <= pct(lo_lim, ctsa_pkg::HYST_HI)) : (mx < lo_lim);
	assign dif_d    = dif_q ? (diff_mag >= pct(sumd_q, ctsa_pkg::HYST_LO)) : (diff_mag > sumd_q);
	assign ratio_ok = (32'(mn) * ctsa_pkg::RATIO_FULL) <= (32'(ratio_q[15:0]) * 32'(mx));
	assign seq_ok   = (32'(neg_seq_current) * ctsa_pkg::RATIO_FULL)
	                  >= (32'(ratio_q[31:16]) * 32'(pos_seq_current));
	assign pick_d   = !over_d && !low_d && ratio_ok && seq_ok && (!res_used || dif_d);
	assign fault_d  = {!seq_ok, !ratio_ok, over_d, low_d};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			over_q <= 1'b0;
			low_q  <= 1'b0;
			dif_q  <= 1'b0;
			pick_q <= 1'b0;
			diff_q <= 16'h0000;
			ang_q  <= 16'h0000;
			nat_q  <= 16'h0000;
		end else if (cycle_start) begin
			over_q <= over_d;
			low_q  <= low_d;
			dif_q  <= dif_d;
			pick_q <= pick_d;
			diff_q <= diff_mag;
			ang_q  <= residual_angle_diff;
			nat_q  <= natural_unbalance_ang;
		end
	end

	// blocking is latched first; start and blocked follow from it in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blk_q     <= 1'b0;
			start_q   <= 1'b0;
			blocked_q <= 1'b0;
		end else if (cycle_start) begin
			blk_q     <= blk_src;
			start_q   <= pick_d && !blk_src;
			blocked_q <= pick_d && blk_src;
		end
	end
	ctsa_dt_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (start_q),
		.delay   (delay_q),
		.alarm   (alarm_t),
		.remain  (remain)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_q  <= 1'b0;
			note_q   <= 1'b0;
			status_q <= ctsa_pkg::ST_NORMAL;
		end else begin
			alarm_q <= alarm_t;
			note_q  <= cycle_start && pick_d && blk_src && !blocked_q;
			if (blocked_q) begin
				status_q <= ctsa_pkg::ST_BLOCKED;
			end else if (alarm_q) begin
				status_q <= ctsa_pkg::ST_TRIP;
			end else if (start_q) begin
				status_q <= ctsa_pkg::ST_START;
			end else begin
				status_q <= ctsa_pkg::ST_NORMAL;
			end
		end
	end

	assign start_out   = start_q;
	assign blocked_out = blocked_q;
	assign alarm_out   = alarm_q;
	assign block_note  = note_q;
	assign status_code = status_q;
	// events: block edges write at once, an alarm edge a cycle later, one more if they meet
	assign keep_on  = ctrl_q[ctsa_pkg::CTRL_KEEP_ON];
	assign keep_off = ctrl_q[ctsa_pkg::CTRL_KEEP_OFF];
	assign blk_ev   = cycle_start && ((pick_d && blk_src) != blocked_q)
	                  && ((pick_d && blk_src) ? keep_on : keep_off);
	assign alm_ev   = (alarm_t != alarm_q) && (alarm_t ? keep_on : keep_off);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q    <= 1'b0;
			pend_on_q <= 1'b0;
		end else if (alm_ev) begin
			pend_q    <= 1'b1;
			pend_on_q <= alarm_t;
		end else if (pend_q && !blk_ev) begin
			pend_q <= 1'b0;
		end
	end

	assign rec_we   = blk_ev || pend_q;
	assign rec_kind = blk_ev ? ((pick_d && blk_src) ? ctsa_pkg::EV_BLOCK_ON
	                                                : ctsa_pkg::EV_BLOCK_OFF)
	                         : (pend_on_q ? ctsa_pkg::EV_ALARM_ON : ctsa_pkg::EV_ALARM_OFF);
	assign rec_wdata = {16'h0000, neg_seq_current, pos_seq_current, residual_input_two,
	                    residual_input_one, phase_l3, phase_l2, phase_l1,
	                    rec_kind, setting_group, fault_d, 4'h0, remain, time_stamp};

	// ring of twelve, index 0 reads the newest
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q  <= 4'h0;
			cnt_q <= 4'h0;
		end else if (rec_we) begin
			wp_q <= (wp_q == ctsa_pkg::REC_LAST) ? 4'h0 : wp_q + 4'h1;
			if (cnt_q != ctsa_pkg::REC_FULL) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	assign ra_t      = {1'b0, wp_q} + {1'b0, ctsa_pkg::REC_LAST} - {1'b0, rsel_q};
	assign rec_raddr = (ra_t >= {1'b0, ctsa_pkg::REC_FULL}) ? 4'(ra_t - {1'b0, ctsa_pkg::REC_FULL})
	                                                       : ra_t[3:0];

	ctsa_rec_mem #(.W(ctsa_pkg::REC_W), .D(ctsa_pkg::REC_DEPTH), .AW(4)) u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (rec_we),
		.waddr   (wp_q),
		.wdata   (rec_wdata),
		.raddr   (rec_raddr),
		.rdata_q (rec_rdata)
	);

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence blk_tick_s;
		cycle_start && blk_src && start_q;
	endsequence
	sequence released_s;
		!start_q ##2 !alarm_q;
	endsequence
	blk_sample_a: assert property (!cycle_start |=> $stable(blk_q))
		else $error("blocking latch moved outside a cycle start");
	start_gate_a: assert property (start_q |-> pick_q && !blk_q && !blocked_q)
		else $error("start without pick-up or with blocking");
	blocked_set_a: assert property (cycle_start && pick_d && blk_src |=> blocked_q && !start_q)
		else $error("blocked pick-up did not give blocked only");
	start_release_a: assert property (blk_tick_s |=> released_s)
		else $error("start and alarm not released on blocking");
	note_pulse_a: assert property (cycle_start && pick_d && blk_src && !blocked_q
		|=> block_note ##1 !block_note)
		else $error("blocking notification missing or stuck");
	over_limit_a: assert property (cycle_start && (mx > up_lim) |=> !pick_q && !start_q)
		else $error("pick-up above upper limit");
	low_limit_a: assert property (cycle_start && (mx < lo_lim) |=> !pick_q && !start_q)
		else $error("pick-up with all phases below lower limit");
	res_diff_a: assert property (cycle_start && res_used
		&& (diff_mag < pct(sumd_q, ctsa_pkg::HYST_LO)) |=> !pick_q)
		else $error("pick-up with residual difference below threshold");
	status_code_a: assert property (##1 status_q == ($past(blocked_q) ? ctsa_pkg::ST_BLOCKED
		: $past(alarm_q) ? ctsa_pkg::ST_TRIP : $past(start_q) ? ctsa_pkg::ST_START
		: ctsa_pkg::ST_NORMAL))
		else $error("status code does not match outputs");
	alarm_event_a: assert property (alm_ev && !blk_ev |=> rec_we && ($past(alarm_t) ==
		(rec_kind == ctsa_pkg::EV_ALARM_ON)))
		else $error("alarm edge was not recorded");
	ring_cap_a: assert property (rec_we && (cnt_q == ctsa_pkg::REC_FULL)
		|=> cnt_q == ctsa_pkg::REC_FULL)
		else $error("record count passed twelve");
endmodule : ctsa_supervision

// >>> tb/ctsa_front_model.sv
`timescale 1ns/100ps
module ctsa_front_model (
	// clock
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// bench request
	input  wire logic        blk_req,
	// towards the block
	output logic             cycle_start,
	output logic      [31:0] time_stamp,
	output logic             block_in
);
	logic [2:0] div_q;
	// program cycle every 8 clocks keeps starts well apart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q       <= 3'h0;
			cycle_start <= 1'b0;
			time_stamp  <= 32'h0000_0000;
		end else begin
			div_q       <= div_q + 3'h1;
			cycle_start <= (div_q == 3'h7);
			time_stamp  <= time_stamp + 32'h0000_0001;
		end
	end
	// pin moves just after a cycle start, so it leads any expiry by one program cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			block_in <= 1'b0;
		else if (div_q == 3'h0)
			block_in <= blk_req;
	end
endmodule : ctsa_front_model

// >>> tb/ctsa_supervision_tb.sv
`timescale 1ns/100ps
module ctsa_supervision_tb;
	localparam int SC = 4;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, blk_req = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata, time_stamp;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [15:0] l1 = 16'h0, l2 = 16'h0, l3 = 16'h0, ps = 16'h0, ng = 16'h0, r1 = 16'h0, cr = 16'h0;
	logic [15:0] r2 = 16'h0, ra = 16'h0, na = 16'h0;
	logic        hreadyout, hresp, cycle_start, block_in, start_out, blocked_out;
	logic        alarm_out, block_note, seen;
	ctsa_pkg::ctsa_status_t status_code;
	int          error_cnt = 0, n_checks = 0, cyc = 0, k;

	ctsa_front_model u_front (.hclk, .hresetn, .blk_req, .cycle_start, .time_stamp, .block_in);
	ctsa_supervision #(.STEP_CYCLES(SC)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cycle_start,
		.phase_l1(l1), .phase_l2(l2), .phase_l3(l3), .residual_input_one(r1),
		.residual_input_two(r2), .pos_seq_current(ps), .neg_seq_current(ng),
		.calc_residual(cr), .residual_angle_diff(ra), .natural_unbalance_ang(na),
		.time_stamp, .setting_group(3'h1), .block_in, .start_out, .blocked_out, .alarm_out,
		.block_note, .status_code);

	always #25 hclk = ~hclk;
	// ceiling far above the few hundred cycles the tests need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic nx(input int n);
		repeat (n) @(negedge hclk);
	endtask : nx

	// ready is sampled at the negedge before the edge that takes it; flops cannot move between
	task automatic wt();
		int i;
		i = 0;
		do begin
			@(negedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 40);
		chk(i < 40 && hresp === 1'b0, "bus hang or error");
		rd = hrdata;
		@(posedge hclk);
	endtask : wt

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h0, a, 2'h2, w, 3'h2};
		wt();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		wt();
	endtask : ahb

	task automatic cur(input logic [79:0] v);
		@(posedge hclk);
		{l1, l2, l3, ps, ng} <= v;
	endtask : cur

	task automatic t_regs();
		ahb(1'b0, ctsa_pkg::OFF_CTRL, 32'h0);
		chk(rd === ctsa_pkg::CTRL_RST, "ctrl reset");
		ahb(1'b0, ctsa_pkg::OFF_LIMIT, 32'h0);
		chk(rd === ctsa_pkg::LIMIT_RST, "limit reset");
		ahb(1'b0, 8'h80, 32'h0);
		chk(rd === 32'h0, "unmapped");
		ahb(1'b1, ctsa_pkg::OFF_DELAY, 32'h2);
		ahb(1'b0, ctsa_pkg::OFF_DELAY, 32'h0);
		chk(rd === 32'h2, "delay");
		$display("test regs done");
	endtask : t_regs

	task automatic t_fault();
		cur({16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0000});
		nx(24);
		chk(start_out === 1'b0 && status_code === ctsa_pkg::ST_NORMAL, "healthy");
		cur({16'h0000, 16'h0064, 16'h0064, 16'h0043, 16'h0021});
		for (k = 0; k < 40 && start_out !== 1'b1; k++) nx(1);
		chk(k < 40 && alarm_out === 1'b0, "start");
		nx(1);
		chk(status_code === ctsa_pkg::ST_START, "status start");
		for (k = 1; k < 40 && alarm_out !== 1'b1; k++) nx(1);
		chk(k >= 9 && k <= 11, "alarm delay");
		nx(1);
		chk(status_code === ctsa_pkg::ST_TRIP, "status trip");
		ahb(1'b0, ctsa_pkg::OFF_STAT, 32'h0);
		chk(rd[12:0] === 13'h022E, "event count and status bits");
		ahb(1'b0, ctsa_pkg::OFF_REC0 + 8'h04, 32'h0);
		chk(rd === 32'h0800_0000, "record kind and group");
		ahb(1'b0, ctsa_pkg::OFF_REC0 + 8'h08, 32'h0);
		chk(rd === 32'h0064_0000, "record phase currents");
		$display("test fault done");
	endtask : t_fault

	// f low drives the matrix pin, f high the forcing switch
	task automatic t_block(input logic f);
		if (f)
			ahb(1'b1, ctsa_pkg::OFF_CTRL, 32'h3C);
		else
			@(posedge hclk) blk_req <= 1'b1;
		for (k = 0; k < 60 && blocked_out !== 1'b1; k++) nx(1);
		chk(k < 60 && start_out === 1'b0, "blocked");
		seen = block_note;
		repeat (3) begin
			nx(1);
			seen |= block_note;
		end
		chk(seen, "note");
		chk(status_code === ctsa_pkg::ST_BLOCKED && alarm_out === 1'b0, "release");
		if (f)
			ahb(1'b1, ctsa_pkg::OFF_CTRL, 32'h30);
		else
			@(posedge hclk) blk_req <= 1'b0;
		for (k = 0; k < 60 && blocked_out !== 1'b0; k++) nx(1);
		chk(k < 60, "unblock");
		$display("test block done");
	endtask : t_block

	task automatic t_limits();
		logic [79:0] tab [2];
		tab[0] = {16'h0000, 16'h00C8, 16'h00C8, 16'h0085, 16'h0043};
		tab[1] = {16'h0000, 16'h0008, 16'h0008, 16'h0005, 16'h0003};
		for (int i = 0; i < 2; i++) begin
			cur(tab[i]);
			nx(24);
			chk(start_out === 1'b0 && blocked_out === 1'b0, "limit");
		end
		$display("test limits done");
	endtask : t_limits

	task automatic t_resid();
		ahb(1'b1, ctsa_pkg::OFF_CTRL, 32'h31);
		@(posedge hclk) {r1, cr} <= {16'h0032, 16'h0032};
		cur({16'h0000, 16'h0064, 16'h0064, 16'h0043, 16'h0021});
		nx(24);
		chk(start_out === 1'b0, "diff low");
		@(posedge hclk) {r1, ra, na} <= {16'h0000, 16'h1234, 16'hFEDC};
		nx(24);
		chk(start_out === 1'b1, "diff high");
		ahb(1'b0, ctsa_pkg::OFF_DIFF, 32'h0);
		chk(rd === 32'h1234_0032, "difference and angle");
		ahb(1'b0, ctsa_pkg::OFF_ANG, 32'h0);
		chk(rd === 32'h0000_FEDC, "unbalance angle");
		@(posedge hclk) r2 <= 16'h0032;
		ahb(1'b1, ctsa_pkg::OFF_CTRL, 32'h32);
		nx(24);
		chk(start_out === 1'b0, "input two selected");
		$display("test resid done");
	endtask : t_resid

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_fault();
		t_block(1'b0);
		t_block(1'b1);
		t_limits();
		t_resid();
		tally_and_finish();
	end
endmodule : ctsa_supervision_tb
